// ---- core/rx_sig_defs.svh ----
// register offsets, field positions and timing counts of the rx signaling block
`ifndef RX_SIG_DEFS_SVH
`define RX_SIG_DEFS_SVH

// ==========================================================
// register map (byte offsets; each bank has one byte address per channel)
`define RX_SIG_ENTRY_BASE   12'h01a0
`define RX_SLIP_LOW_BASE    12'h01c0
`define RX_SLIP_HIGH_BASE   12'h01e0
`define RX_SIG_CTRL_ADDR    12'h0200
`define RX_SIG_STAT_ADDR    12'h0204
`define RX_SIG_MASK_ADDR    12'h0208

// ==========================================================
// control register fields
`define CTRL_T1_MODE        0
`define CTRL_FILTER_EN      1
`define CTRL_THREE_MF       2
`define CTRL_NO_SIG_FMT     3
`define CTRL_WIDTH          4

// ==========================================================
// entry layout and timing
`define SIG_OUT_HI          7
`define SIG_OUT_LO          4
`define SIG_IN_HI           3
`define SIG_IN_LO           0
`define T1_FRAMES_PER_XFER  5'd24
`define RESET_SYNC_STAGES   2

`endif

// ---- core/rx_sig_pkg.sv ----
// types shared by the rx signaling block
package rx_sig_pkg;

	// one received signaling event from the framer
	typedef struct packed {
		logic       valid;   // sample present this cycle
		logic [4:0] chan;    // channel index 0..31
		logic [1:0] bit_idx; // 0=A 1=B 2=C 3=D
		logic       value;   // received bit
		logic       nibble;  // e1: whole abcd nibble present
		logic [3:0] abcd;    // e1 nibble, a in bit 3
	} sig_sample_t;

	// one received pcm bit from the framer
	typedef struct packed {
		logic       valid;   // bit present this cycle
		logic [4:0] chan;    // time slot 0..31
		logic       high;    // write the high bank
		logic       first;   // first bit of the slot
		logic       value;   // received bit
	} pcm_bit_t;

	// control fields steering the update logic
	typedef struct packed {
		logic no_sig_fmt;   // framing with no signaling
		logic three_mf;     // three-multiframe storage
		logic filter_en;    // signaling filter
		logic t1_mode;      // 1 = t1, 0 = e1
	} sig_ctrl_t;

endpackage

// ---- core/rx_sig_debounce.sv ----
// one-bit signaling filter: new buffered bits for multiframe n and n-1
`timescale 1ns/1ps
module rx_sig_debounce (
	input  wire logic i_in,      // newly sampled bit
	input  wire logic i_n,       // buffered bit of multiframe n
	input  wire logic i_n1,      // buffered bit of multiframe n-1
	input  wire logic i_enable,  // filter active
	output logic      o_n,       // updated bit n
	output logic      o_n1       // updated bit n-1
);
	// differs from n but equals n-1: invert n's bit before shifting
	always_comb begin
		if (i_enable && (i_in != i_n) && (i_in == i_n1)) begin
			o_n  = i_in;                 // [RULE9]
			o_n1 = ~i_n;                 // [RULE9]
		end else begin
			o_n  = i_in;
			o_n1 = i_n;
		end
	end
endmodule

// ---- core/rx_slip_byte.sv ----
// serial-in shift for one received pcm time slot byte
`timescale 1ns/1ps
module rx_slip_byte (
	input  wire logic       i_first,  // first bit of the slot
	input  wire logic       i_value,  // received bit
	input  wire logic [7:0] i_acc,    // bits collected so far
	output logic [7:0]      o_acc,    // accumulator after this bit
	output logic [2:0]      o_cnt_inc // unused width guard
);
	// the first bit shifts in on the right and walks up to bit 7
	always_comb begin
		if (i_first) begin
			o_acc = {7'h00, i_value};                 // [RULE7]
		end else begin
			o_acc = {i_acc[6:0], i_value};            // [RULE7]
		end
		o_cnt_inc = 3'h1;
	end
endmodule

// ---- core/rx_signaling_slip_buffers.sv ----
// receive signaling buffer and pcm slip buffer with avalon-mm access
// Function
// [RULE1] one signaling entry per channel 0..31 captures abcd for all channels.
// [RULE2] while signaling freeze is present no entry is changed.
// [RULE3] a framing format without signaling leaves the entries untouched.
// [RULE4] t1 without filter copies input abcd to output when the d bit updates.
// [RULE5] e1 copies input abcd to output when the ts16 nibble arrives.
// [RULE6] with the filter on, output follows each sampled input bit.
// [RULE7] slip bytes hold the first received bit in bit 7, the eighth in bit 0.
// [RULE8] entry bits 7..4 are output abcd and bits 3..0 input abcd.
// [RULE9] t1 filter inverts bit n when input differs from n but equals n-1.
// [RULE10] t1 three-multiframe storage moves input to output every 24 frames.
`timescale 1ns/1ps
module rx_signaling_slip_buffers
	import rx_sig_pkg::*;
#(
	parameter int CHANNELS = 32
) (
	input  wire logic        i_clk_sys,        // 125 mhz system clock
	input  wire logic        i_rstn,           // async reset, active low
	input  wire logic [11:0] i_avs_address,    // byte address
	input  wire logic        i_avs_read,       // read request
	input  wire logic        i_avs_write,      // write request
	input  wire logic [31:0] i_avs_writedata,  // write data
	input  wire logic [3:0]  i_avs_byteenable, // byte lanes
	output logic [31:0]      o_avs_readdata,   // read data
	output logic             o_avs_waitrequest,// stall
	output logic [1:0]       o_avs_response,   // 00 ok, 10 slave error
	input  wire sig_sample_t i_sig,            // framer signaling sample
	input  wire pcm_bit_t    i_pcm,            // framer pcm bit
	input  wire logic        i_sig_freeze,     // signaling freeze condition
	input  wire logic        i_frame_pulse,    // one pulse per rx frame
	output logic [7:0]       o_frame_count     // frames since last transfer
);
	`include "rx_sig_defs.svh"

	// the five-bit channel index and the 32-byte banks fix the count
	if (CHANNELS != 32) begin : g_bad_channels
		$error("rx_signaling_slip_buffers serves exactly 32 channels");
	end

	// ======================================================
	// reset release
	logic [1:0] rst_sync_q;
	logic       rstn;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rstn = rst_sync_q[1];

	// ======================================================
	// storage
	logic [3:0] sig_out_q [CHANNELS];
	logic [3:0] sig_in_q  [CHANNELS];
	logic [3:0] sig_old_q [CHANNELS];
	logic [7:0] slip_lo_q [CHANNELS];
	logic [7:0] slip_hi_q [CHANNELS];
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	sig_ctrl_t  ctrl_q;
	logic [4:0] frame_cnt_q;

	// ======================================================
	// avalon slave: one-cycle wait, then answer
	logic        ack_q;
	logic        req;
	logic        sel_sig;
	logic        sel_lo;
	logic        sel_hi;
	logic        sel_ctrl;
	logic        sel_stat;
	logic [4:0]  idx;
	logic        mapped;
	logic        wr_fire;
	logic        rd_fire;

	assign req     = i_avs_read | i_avs_write;
	// each bank is 32 consecutive byte addresses, one per channel,
	// so no bank overlaps the next and every channel is reachable
	assign idx     = i_avs_address[4:0];
	assign sel_sig = (i_avs_address[11:5] ==
			7'(`RX_SIG_ENTRY_BASE >> 5));                    // [RULE1]
	assign sel_lo  = (i_avs_address[11:5] ==
			7'(`RX_SLIP_LOW_BASE >> 5));
	assign sel_hi  = (i_avs_address[11:5] ==
			7'(`RX_SLIP_HIGH_BASE >> 5));
	assign sel_ctrl = (i_avs_address == `RX_SIG_CTRL_ADDR);
	assign sel_stat = (i_avs_address == `RX_SIG_STAT_ADDR);
	assign mapped  = sel_sig | sel_lo | sel_hi | sel_ctrl | sel_stat;
	assign o_avs_waitrequest = req & ~ack_q;
	assign wr_fire = i_avs_write & ack_q;
	assign rd_fire = i_avs_read & ack_q;

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			o_avs_readdata <= 32'h0000_0000;
			o_avs_response <= 2'b00;
		end else if (req & ~ack_q) begin
			o_avs_response <= mapped ? 2'b00 : 2'b10;
			if (!i_avs_read || !mapped) begin
				o_avs_readdata <= 32'h0000_0000;
			end else if (sel_sig) begin
				o_avs_readdata <= {24'h00_0000, sig_out_q[idx],
						sig_in_q[idx]};                 // [RULE8]
			end else if (sel_lo) begin
				o_avs_readdata <= {24'h00_0000, slip_lo_q[idx]};
			end else if (sel_hi) begin
				o_avs_readdata <= {24'h00_0000, slip_hi_q[idx]};
			end else if (sel_ctrl) begin
				o_avs_readdata <= {28'h000_0000, ctrl_q};
			end else begin
				o_avs_readdata <= {27'h000_0000, frame_cnt_q};
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= '0;
			ctrl_q.t1_mode <= 1'b1;
		end else if (wr_fire && sel_ctrl && i_avs_byteenable[0]) begin
			ctrl_q <= i_avs_writedata[`CTRL_WIDTH-1:0];
		end
	end

	// ======================================================
	// t1 frame counter for three-multiframe storage
	logic xfer24;
	assign xfer24 = i_frame_pulse &&
			(frame_cnt_q == `T1_FRAMES_PER_XFER - 5'd1);
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			frame_cnt_q <= 5'd0;
		end else if (xfer24) begin
			frame_cnt_q <= 5'd0;                           // [RULE10]
		end else if (i_frame_pulse) begin
			frame_cnt_q <= frame_cnt_q + 5'd1;
		end
	end
	assign o_frame_count = {3'b000, frame_cnt_q};

	// ======================================================
	// signaling update
	logic       sig_ok;
	logic [3:0] bit_mask;
	logic       new_n;
	logic       new_n1;
	logic [3:0] in_upd;
	logic [3:0] old_upd;

	assign sig_ok   = !i_sig_freeze && !ctrl_q.no_sig_fmt; // [RULE2] [RULE3]
	assign bit_mask = 4'b1000 >> i_sig.bit_idx;

	rx_sig_debounce u_debounce (
		.i_in     (i_sig.value),
		.i_n      (|(sig_in_q[i_sig.chan] & bit_mask)),
		.i_n1     (|(sig_old_q[i_sig.chan] & bit_mask)),
		.i_enable (ctrl_q.filter_en & ctrl_q.t1_mode),
		.o_n      (new_n),
		.o_n1     (new_n1)
	);

	always_comb begin
		in_upd  = sig_in_q[i_sig.chan];
		old_upd = sig_old_q[i_sig.chan];
		in_upd  = new_n ? (in_upd | bit_mask) : (in_upd & ~bit_mask);
		old_upd = new_n1 ? (old_upd | bit_mask) : (old_upd & ~bit_mask);
	end

	// every channel is captured; per-channel enables do not gate it
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < CHANNELS; c++) begin
				sig_in_q[c]  <= 4'h0;
				sig_old_q[c] <= 4'h0;
				sig_out_q[c] <= 4'h0;
			end
		end else if (sig_ok) begin
			if (i_sig.valid && ctrl_q.t1_mode) begin
				sig_in_q[i_sig.chan]  <= in_upd;             // [RULE1]
				sig_old_q[i_sig.chan] <= old_upd;            // [RULE9]
				if (ctrl_q.filter_en) begin
					sig_out_q[i_sig.chan] <= in_upd;     // [RULE6]
				end else if (!ctrl_q.three_mf &&
						i_sig.bit_idx == 2'd3) begin
					sig_out_q[i_sig.chan] <= in_upd;     // [RULE4]
				end
			end else if (i_sig.valid && i_sig.nibble) begin
				sig_in_q[i_sig.chan]  <= i_sig.abcd;         // [RULE1]
				sig_out_q[i_sig.chan] <= i_sig.abcd;         // [RULE5]
			end
			// three-multiframe storage ignores the d-bit moment
			if (ctrl_q.t1_mode && ctrl_q.three_mf &&
					!ctrl_q.filter_en && xfer24) begin
				for (int c = 0; c < CHANNELS; c++) begin
					sig_out_q[c] <= sig_in_q[c];         // [RULE10]
				end
			end
		end
	end

	// ======================================================
	// pcm slip buffer
	rx_slip_byte u_slip (
		.i_first   (i_pcm.first),
		.i_value   (i_pcm.value),
		.i_acc     (acc_q),
		.o_acc     (acc_d),
		.o_cnt_inc ()
	);

	logic [2:0] pcm_cnt_q;
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_q     <= 8'h00;
			pcm_cnt_q <= 3'd0;
		end else if (i_pcm.valid) begin
			acc_q     <= acc_d;
			pcm_cnt_q <= i_pcm.first ? 3'd1 : pcm_cnt_q + 3'd1;
		end
	end

	// eighth bit completes the byte; software writes also land here
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < CHANNELS; c++) begin
				slip_lo_q[c] <= 8'h00;
				slip_hi_q[c] <= 8'h00;
			end
		end else begin
			if (wr_fire && sel_lo && i_avs_byteenable[0]) begin
				slip_lo_q[idx] <= i_avs_writedata[7:0];
			end
			if (wr_fire && sel_hi && i_avs_byteenable[0]) begin
				slip_hi_q[idx] <= i_avs_writedata[7:0];
			end
			if (i_pcm.valid && pcm_cnt_q == 3'd7 && !i_pcm.first) begin
				if (i_pcm.high) begin
					slip_hi_q[i_pcm.chan] <= acc_d;      // [RULE7]
				end else begin
					slip_lo_q[i_pcm.chan] <= acc_d;      // [RULE7]
				end
			end
		end
	end
endmodule

// ---- tb/rx_sig_chk.sv ----
// checker for the bus handshake and the frame counter
`timescale 1ns/1ps
`include "rx_sig_defs.svh"
module rx_sig_chk (
	input  wire logic        i_clk_sys,         // clock
	input  wire logic        i_rstn,            // reset, active low
	input  wire logic [11:0] i_avs_address,     // address
	input  wire logic        i_avs_read,        // read
	input  wire logic        i_avs_write,       // write
	input  wire logic [31:0] o_avs_readdata,    // read data
	input  wire logic        o_avs_waitrequest, // stall
	input  wire logic [1:0]  o_avs_response,    // response
	input  wire logic        i_frame_pulse,     // frame pulse
	input  wire logic [7:0]  o_frame_count      // frame count
);
	// ==========================================================
	// properties
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	wire req = i_avs_read | i_avs_write;
	wire done = req & !o_avs_waitrequest;
	a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
		else $error("no wait state on a new request");
	a_wait_one: assert property ($rose(req) |=> !o_avs_waitrequest)
		else $error("wait state longer than one cycle");
	a_idle_free: assert property (!req |-> !o_avs_waitrequest)
		else $error("waitrequest without a request");
	a_bad_addr: assert property (done && i_avs_address == `RX_SIG_MASK_ADDR
		|-> o_avs_response == 2'b10) else $error("unmapped access not refused");
	a_bad_zero: assert property (done && i_avs_read && i_avs_address ==
		`RX_SIG_MASK_ADDR |-> o_avs_readdata == 32'h0000_0000)
		else $error("unmapped read data not zero");
	a_good_rsp: assert property (done && i_avs_address == `RX_SIG_CTRL_ADDR
		|-> o_avs_response == 2'b00) else $error("mapped access refused");
	a_count_top: assert property (o_frame_count <= 8'h17)
		else $error("frame count above 23");
	a_count_step: assert property (i_frame_pulse |=> o_frame_count ==
		(($past(o_frame_count) == 8'h17) ? 8'h00 : $past(o_frame_count) + 8'h01))
		else $error("frame count step wrong");
	a_count_hold: assert property (!i_frame_pulse |=> $stable(o_frame_count))
		else $error("frame count moved without a pulse");
	c_bad_addr: cover property (done && i_avs_address == `RX_SIG_MASK_ADDR);
	c_wrap: cover property (i_frame_pulse && o_frame_count == 8'h17);
	c_write: cover property (done && i_avs_write);
endmodule
bind rx_signaling_slip_buffers rx_sig_chk rx_sig_chk_inst (.i_clk_sys,
	.i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
	.o_avs_waitrequest, .o_avs_response, .i_frame_pulse, .o_frame_count);

// ---- tb/rx_framer_model.sv ----
// receive framer model: signaling samples, pcm bits and frame pulses
`timescale 1ns/1ps
module rx_framer_model
	import rx_sig_pkg::*;
(
	input  wire logic  i_clk_sys,    // clock
	output sig_sample_t o_sig,       // signaling sample
	output pcm_bit_t    o_pcm,       // pcm bit
	output logic        o_frame_pulse // frame pulse
);
	// ==========================================================
	// drivers: payload is inverted after the strobe so stale data never passes
	initial begin
		o_sig = '0;
		o_pcm = '0;
		o_frame_pulse = 1'b0;
	end
	task automatic sample(input logic [4:0] ch, input logic [1:0] idx,
		input logic v, input logic nib, input logic [3:0] abcd);
		@(posedge i_clk_sys);
		o_sig <= '{1'b1, ch, idx, v, nib, abcd};
		@(posedge i_clk_sys);
		o_sig <= '{1'b0, ~ch, ~idx, ~v, ~nib, ~abcd};
	endtask
	task automatic pcm_byte(input logic [4:0] ch, input logic hi,
		input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge i_clk_sys);
			o_pcm <= '{1'b1, ch, hi, i == 7, b[i]};
		end
		@(posedge i_clk_sys);
		o_pcm <= '{1'b0, ~ch, ~hi, 1'b0, ~b[0]};
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			o_frame_pulse <= 1'b1;
			@(posedge i_clk_sys);
			o_frame_pulse <= 1'b0;
		end
	endtask
endmodule

// ---- tb/tb.sv ----
// testbench: register reads of signaling entries, slip bytes and control
`timescale 1ns/1ps
`include "rx_sig_defs.svh"
module tb;
	import rx_sig_pkg::*;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, frz = 0, fp, wt;
	logic [11:0] addr = '0;
	logic [31:0] wd = '0, rdata, q;
	logic [1:0] rsp, r;
	logic [7:0] fc;
	sig_sample_t sig;
	pcm_bit_t pcm;
	int fails = 0, n_checks = 0, cyc = 0;
	always #4 clk = ~clk;
	rx_signaling_slip_buffers rx_signaling_slip_buffers_inst (
		.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wt), .o_avs_response(rsp), .i_sig(sig),
		.i_pcm(pcm), .i_sig_freeze(frz), .i_frame_pulse(fp),
		.o_frame_count(fc));
	rx_framer_model rx_framer_model_inst (.i_clk_sys(clk), .o_sig(sig),
		.o_pcm(pcm), .o_frame_pulse(fp));
	// ==========================================================
	// tasks
	task automatic chk(input logic [11:0] a, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR reg %h expected %h seen %h", a, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
		q = rdata;
		r = rsp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(a, q, {24'h00_0000, e});
	endtask
	function automatic logic [11:0] ent(input int n);
		return `RX_SIG_ENTRY_BASE + 12'(n);
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// timeout well above the roughly 185 cycles the sequence takes
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			conclude();
		end
	end
	// ==========================================================
	// sequence
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(`RX_SIG_CTRL_ADDR, 8'h01);
		bus(1'b0, `RX_SIG_MASK_ADDR, 32'h0000_0000);
		chk(`RX_SIG_MASK_ADDR, {30'h0, r}, 32'h0000_0002);
		chk(`RX_SIG_MASK_ADDR, q, 32'h0000_0000);
		rx_framer_model_inst.pcm_byte(5'd0, 1'b0, 8'ha5);
		rx_framer_model_inst.pcm_byte(5'd0, 1'b1, 8'h3c);
		rchk(`RX_SLIP_LOW_BASE, 8'ha5);
		rchk(`RX_SLIP_HIGH_BASE, 8'h3c);
		rx_framer_model_inst.pcm_byte(5'd31, 1'b1, 8'h81);
		rchk(`RX_SLIP_HIGH_BASE + 12'h01f, 8'h81);
		bus(1'b1, `RX_SLIP_LOW_BASE + 12'h001, 32'h0000_005a);
		rchk(`RX_SLIP_LOW_BASE + 12'h001, 8'h5a);
		for (int i = 0; i < 3; i++)
			rx_framer_model_inst.sample(5'd3, 2'(i), i != 1, 1'b0, 4'h0);
		rchk(ent(3), 8'h0a);
		rx_framer_model_inst.sample(5'd3, 2'd3, 1'b1, 1'b0, 4'h0);
		rchk(ent(3), 8'hbb);
		frz <= 1'b1;
		rx_framer_model_inst.sample(5'd3, 2'd3, 1'b0, 1'b0, 4'h0);
		rchk(ent(3), 8'hbb);
		frz <= 1'b0;
		bus(1'b1, `RX_SIG_CTRL_ADDR, 32'h0000_0009);
		rx_framer_model_inst.sample(5'd3, 2'd3, 1'b0, 1'b0, 4'h0);
		rchk(ent(3), 8'hbb);
		bus(1'b1, `RX_SIG_CTRL_ADDR, 32'h0000_0000);
		rx_framer_model_inst.sample(5'd5, 2'd0, 1'b0, 1'b1, 4'h6);
		rchk(ent(5), 8'h66);
		rx_framer_model_inst.sample(5'd31, 2'd0, 1'b0, 1'b1, 4'h9);
		rchk(ent(31), 8'h99);
		bus(1'b1, `RX_SIG_CTRL_ADDR, 32'h0000_0005);
		for (int i = 0; i < 4; i++)
			rx_framer_model_inst.sample(5'd4, 2'(i), 1'b1, 1'b0, 4'h0);
		rx_framer_model_inst.frames(23);
		rchk(ent(4), 8'h0f);
		rchk(`RX_SIG_STAT_ADDR, 8'h17);
		rx_framer_model_inst.frames(1);
		rchk(ent(4), 8'hff);
		rchk(`RX_SIG_STAT_ADDR, 8'h00);
		bus(1'b1, `RX_SIG_CTRL_ADDR, 32'h0000_0003);
		rx_framer_model_inst.sample(5'd6, 2'd0, 1'b1, 1'b0, 4'h0);
		rchk(ent(6), 8'h88);
		rx_framer_model_inst.sample(5'd6, 2'd0, 1'b0, 1'b0, 4'h0);
		rchk(ent(6), 8'h00);
		conclude();
	end
endmodule
